/* File: design/btr_timer.sv */
// Basic 8-bit timer with prescaler, RTC source, flag and green wake-up
// Operation
// - Enable bit low holds, high advances count
// - Count steps per tick; wrap FF to 00 overflows
// - Overflow sets flag until software writes zero
// - No reload; count continues from zero
// - Enabled flag requests interrupt at vector 8
// - Counts in all modes; green overflow wakes
// - Wake returns to mode before green
// - Rate field picks divide 256 down to 2
// - RTC select low uses prescaled instruction clock
// - RTC select high uses crystal over 64
// - RTC mode ignores rate, full 256 steps
// - Mode register layout, unused bits, zero reset
// - Count register readable, writable, resets zero
module btr_timer (
  input wire logic clk, // Instruction clock, 200 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWdata, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [7:0] regRdata, // Read data, cycle after strobe
  input wire logic crystalIn, // Low-speed crystal pin level
  input wire logic [1:0] powerMode, // Current system power mode
  output logic irqReq, // Overflow interrupt request
  output logic [7:0] irqVector, // Vector for the request
  output logic wakeUp, // Green mode wake pulse
  output logic [1:0] resumeMode, // Mode to return to on wake
  output logic eventIrq // Masked event status interrupt
);
  // Mode register fields
  logic runEn_q; // Timer run enable
  logic [2:0] rate_q; // Prescale select
  logic rtcSel_q; // RTC source select
  // Count and flags
  logic [7:0] count_q; // Count value
  logic flag_q; // Overflow flag
  logic ien_q; // Overflow interrupt enable
  logic [btr_pkg::EV_W-1:0] status_q; // Sticky events
  logic [btr_pkg::EV_W-1:0] mask_q; // Event mask
  btr_pkg::btr_pwr_e prior_q; // Mode before green
  btr_pkg::btr_pwr_e powerNow; // Current mode as enum
  logic [7:0] rdata_q; // Registered read data
  logic wake_q; // Registered wake pulse
  // Decoded strobes
  logic wrMode; // Write to mode register
  logic wrCount; // Write to count register
  logic wrIrq; // Write to interrupt control
  logic wrMask; // Write to mask
  logic rdStatus; // Read of status
  // Timer steps
  logic countEn; // Count advances this cycle
  logic overflow; // Wrap from full scale
  logic inGreen; // System is in green mode
  logic [btr_pkg::EV_W-1:0] events; // Events this cycle
  logic [7:0] rdMux; // Read data selection

  // Tick sources
  btr_tick_if preBus (); // Prescaler link
  btr_tick_if rtcBus (); // Crystal divider link

  assign powerNow = btr_pkg::btr_pwr_e'(powerMode);
  assign inGreen = powerNow == btr_pkg::PWR_GREEN;

  // Prescaler runs only when selected and enabled
  assign preBus.run = runEn_q & ~rtcSel_q;
  assign preBus.rate = rate_q;
  // Crystal divider runs only in RTC mode
  assign rtcBus.run = runEn_q & rtcSel_q;
  assign rtcBus.rate = 3'h0; // Rate not used in RTC mode

  btr_prescaler uPre (
    .clk(clk),
    .reset(reset),
    .tickPort(preBus)
  );

  btr_rtc_tick uRtc (
    .clk(clk),
    .reset(reset),
    .crystalIn(crystalIn),
    .tickPort(rtcBus)
  );

  // Address decode
  always_comb
  begin
    wrMode = 1'b0;
    wrCount = 1'b0;
    wrIrq = 1'b0;
    wrMask = 1'b0;
    rdStatus = 1'b0;
    if (regAddr == btr_pkg::MODE_OFS)
      wrMode = regWr;
    else if (regAddr == btr_pkg::COUNT_OFS)
      wrCount = regWr;
    else if (regAddr == btr_pkg::IRQCTL_OFS)
      wrIrq = regWr;
    else if (regAddr == btr_pkg::MASK_OFS)
      wrMask = regWr;
    else if (regAddr == btr_pkg::STATUS_OFS)
      rdStatus = regRd;
  end

  // Count enable from the selected source; rate ignored in RTC mode
  assign countEn = runEn_q & (rtcSel_q ? rtcBus.tick : preBus.tick);
  // A software write to the count takes priority over the step
  assign overflow = countEn & ~wrCount & (count_q == btr_pkg::COUNT_FULL);

  // Events for the sticky status
  always_comb
  begin
    events = '0;
    events[btr_pkg::EV_OVF_BIT] = overflow;
    events[btr_pkg::EV_WAKE_BIT] = overflow & inGreen;
  end

  // Mode register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      runEn_q <= btr_pkg::MODE_RST[btr_pkg::RUN_BIT];
      rate_q <= btr_pkg::MODE_RST[btr_pkg::RATE_MSB:btr_pkg::RATE_LSB];
      rtcSel_q <= btr_pkg::MODE_RST[btr_pkg::RTC_BIT];
    end
    else if (wrMode)
    begin
      runEn_q <= regWdata[btr_pkg::RUN_BIT];
      rate_q <= regWdata[btr_pkg::RATE_MSB:btr_pkg::RATE_LSB];
      rtcSel_q <= regWdata[btr_pkg::RTC_BIT];
    end
  end

  // Count register: load, step or hold; wrap is plain, no reload
  always_ff @(posedge clk)
  begin
    if (reset)
      count_q <= btr_pkg::COUNT_RST;
    else if (wrCount)
      count_q <= regWdata;
    else if (countEn)
      count_q <= count_q + btr_pkg::COUNT_ONE;
  end

  // Overflow flag: set beats a clear written in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      flag_q <= 1'b0;
    else if (overflow)
      flag_q <= 1'b1;
    else if (wrIrq)
      flag_q <= flag_q & regWdata[btr_pkg::FLAG_BIT];
  end

  // Overflow interrupt enable
  always_ff @(posedge clk)
  begin
    if (reset)
      ien_q <= 1'b0;
    else if (wrIrq)
      ien_q <= regWdata[btr_pkg::IEN_BIT];
  end

  // Request stays up until software drops the flag or the enable
  assign irqReq = flag_q & ien_q;
  assign irqVector = btr_pkg::IRQ_VECTOR;

  // Sticky status, cleared by a read; new events win over the clear
  always_ff @(posedge clk)
  begin
    if (reset)
      status_q <= btr_pkg::EV_RST;
    else
      status_q <= (rdStatus ? btr_pkg::EV_RST : status_q) | events;
  end

  // Event mask
  always_ff @(posedge clk)
  begin
    if (reset)
      mask_q <= btr_pkg::EV_RST;
    else if (wrMask)
      mask_q <= regWdata[btr_pkg::EV_W-1:0];
  end

  assign eventIrq = |(status_q & mask_q);

  // Remember the mode in force before green mode
  always_ff @(posedge clk)
  begin
    if (reset)
      prior_q <= btr_pkg::PWR_NORMAL;
    else if (!inGreen)
      prior_q <= powerNow;
  end

  // Wake pulse on an overflow seen in green mode
  always_ff @(posedge clk)
  begin
    if (reset)
      wake_q <= 1'b0;
    else
      wake_q <= overflow & inGreen;
  end

  assign wakeUp = wake_q;
  assign resumeMode = prior_q;

  // Read data selection; unmapped addresses read zero
  always_comb
  begin
    rdMux = 8'h00;
    if (regAddr == btr_pkg::MODE_OFS)
    begin
      rdMux[btr_pkg::RUN_BIT] = runEn_q;
      rdMux[btr_pkg::RATE_MSB:btr_pkg::RATE_LSB] = rate_q;
      rdMux[btr_pkg::RTC_BIT] = rtcSel_q;
    end
    else if (regAddr == btr_pkg::COUNT_OFS)
      rdMux = count_q;
    else if (regAddr == btr_pkg::IRQCTL_OFS)
    begin
      rdMux[btr_pkg::FLAG_BIT] = flag_q;
      rdMux[btr_pkg::IEN_BIT] = ien_q;
    end
    else if (regAddr == btr_pkg::STATUS_OFS)
      rdMux[btr_pkg::EV_W-1:0] = status_q;
    else if (regAddr == btr_pkg::MASK_OFS)
      rdMux[btr_pkg::EV_W-1:0] = mask_q;
  end

  // Read data registered, valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (regRd)
      rdata_q <= rdMux;
    else
      rdata_q <= 8'h00;
  end

  assign regRdata = rdata_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Count holds while stopped and not written
  property p_hold;
    !runEn_q && !wrCount |=> count_q == $past(count_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while stopped");

  // Each enable without a count write steps the count by exactly one
  property p_step;
    countEn && !wrCount |=> count_q == $past(count_q) + btr_pkg::COUNT_ONE;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step by one");

  // Overflow lands at zero with the flag set in the next cycle
  sequence s_wrap;
    countEn && !wrCount && count_q == btr_pkg::COUNT_FULL;
  endsequence
  sequence s_landed;
    count_q == 8'h00 && flag_q;
  endsequence
  property p_wrap;
    s_wrap |=> s_landed;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not reach zero with flag set");

  // Flag survives any cycle without a zero write
  property p_flag_keep;
    flag_q && !(wrIrq && !regWdata[btr_pkg::FLAG_BIT]) |=> flag_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("overflow flag lost without clear");

  // Enabled flag raises the request at vector eight
  property p_irq;
    flag_q && ien_q |-> irqReq && irqVector == 8'h08;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request missing");

  // Green overflow wakes one cycle later for one cycle
  property p_wake;
    overflow && inGreen |=> wakeUp ##1 !wakeUp;
  endproperty
  a_wake: assert property (p_wake)
    else $error("green overflow did not wake");

  // Wake never asks to stay in green
  property p_resume;
    wakeUp |-> resumeMode != btr_pkg::PWR_GREEN;
  endproperty
  a_resume: assert property (p_resume)
    else $error("wake resumes into green mode");

  // RTC mode steps only on crystal ticks, whatever the rate
  property p_rtc_src;
    runEn_q && rtcSel_q |-> countEn == rtcBus.tick;
  endproperty
  a_rtc_src: assert property (p_rtc_src)
    else $error("RTC mode stepped from prescaler");

  // Unused mode bits read zero
  property p_mode_rd;
    regRd && regAddr == btr_pkg::MODE_OFS |=> regRdata[3:1] == 3'h0;
  endproperty
  a_mode_rd: assert property (p_mode_rd)
    else $error("unused mode bits read nonzero");

  // Written count reads back next
  property p_count_rw;
    wrCount ##1 (regRd && regAddr == btr_pkg::COUNT_OFS && !countEn)
      |=> regRdata == $past(regWdata, 2);
  endproperty
  a_count_rw: assert property (p_count_rw)
    else $error("count write did not read back");
endmodule

/* File: design/btr_pkg.sv */
// Constants, field layout and types of the basic 8-bit timer with RTC
package btr_pkg;
  // Register offsets on the core bus
  localparam logic [7:0] MODE_OFS = 8'hd8; // Mode control register
  localparam logic [7:0] COUNT_OFS = 8'hd9; // Count value register
  localparam logic [7:0] IRQCTL_OFS = 8'hda; // Flag and interrupt enable
  localparam logic [7:0] STATUS_OFS = 8'hdb; // Sticky event status
  localparam logic [7:0] MASK_OFS = 8'hdc; // Event interrupt mask
  // Mode register fields
  localparam int RUN_BIT = 7; // Timer run enable
  localparam int RATE_LSB = 4; // Prescale select, low bit
  localparam int RATE_MSB = 6; // Prescale select, high bit
  localparam int RTC_BIT = 0; // RTC source select
  localparam logic [7:0] MODE_USED = 8'hf1; // Implemented mode bits
  // Interrupt control fields
  localparam int FLAG_BIT = 0; // Overflow flag
  localparam int IEN_BIT = 1; // Overflow interrupt enable
  // Event status and mask fields
  localparam int EV_OVF_BIT = 0; // Overflow event
  localparam int EV_WAKE_BIT = 1; // Green mode wake event
  localparam int EV_W = 2; // Number of events
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00; // Mode register reset
  localparam logic [7:0] COUNT_RST = 8'h00; // Count register reset
  localparam logic [EV_W-1:0] EV_RST = 2'h0; // Status and mask reset
  // Count limits
  localparam logic [7:0] COUNT_FULL = 8'hff; // Full scale before wrap
  localparam logic [7:0] COUNT_ONE = 8'h01; // Count increment
  localparam logic [7:0] PRE_MASK_ALL = 8'hff; // Prescale mask for /256
  localparam logic [7:0] IRQ_VECTOR = 8'h08; // Interrupt vector address
  // Low-speed crystal divider
  localparam int RTC_DIV = 64; // Crystal edges per timer step
  localparam int RTC_DIV_W = 6; // Divider width
  localparam logic [RTC_DIV_W-1:0] RTC_DIV_LAST = 6'h3f; // Last edge
  // System power modes
  typedef enum logic [1:0] {PWR_NORMAL, PWR_SLOW, PWR_GREEN} btr_pwr_e;
endpackage

/* File: design/btr_tick_if.sv */
// Tick source interface between the timer core and its clock sources
interface btr_tick_if;
  logic run; // Source may run
  logic [2:0] rate; // Prescale select
  logic tick; // One-cycle count enable
  modport src (input run, input rate, output tick);
  modport sink (output run, output rate, input tick);
endinterface

/* File: design/btr_prescaler.sv */
// Instruction clock prescaler, divide by 256 down to divide by 2
module btr_prescaler (
  input wire logic clk, // Instruction clock
  input wire logic reset, // Synchronous reset, active high
  btr_tick_if.src tickPort // Run, rate and tick
);
  logic [7:0] preCnt_q; // Free divider count
  logic [7:0] preMask; // Low bits that must be all ones
  logic atEnd; // Divider at its last cycle

  // Mask shrinks as the rate field grows
  assign preMask = btr_pkg::PRE_MASK_ALL >> tickPort.rate;
  assign atEnd = (preCnt_q & preMask) == preMask;
  assign tickPort.tick = tickPort.run & atEnd;

  // Divider restarts when stopped so a full period precedes the first tick
  always_ff @(posedge clk)
  begin
    if (reset || !tickPort.run)
      preCnt_q <= 8'h00;
    else
      preCnt_q <= preCnt_q + btr_pkg::COUNT_ONE;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Fastest rate ticks every second cycle
  sequence s_fast_run;
    tickPort.run && tickPort.rate == 3'h7;
  endsequence
  // Run and rate must stay put for the whole two-cycle span
  property p_div_two;
    (s_fast_run ##0 tickPort.tick) ##1 s_fast_run ##1 s_fast_run
      |-> tickPort.tick;
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("divide by two tick missing");
endmodule

/* File: design/btr_rtc_tick.sv */
// Low-speed crystal sampler and divide by 64 tick generator
module btr_rtc_tick (
  input wire logic clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic crystalIn, // Low-speed crystal level
  btr_tick_if.src tickPort // Run in, tick out
);
  logic sync1_q; // First synchroniser stage
  logic sync2_q; // Second synchroniser stage
  logic sync3_q; // Edge history
  logic [btr_pkg::RTC_DIV_W-1:0] div_q; // Crystal edge count
  logic tick_q; // Registered tick
  logic rise; // Crystal rising edge seen

  assign rise = sync2_q & ~sync3_q;
  assign tickPort.tick = tick_q;

  // Two-flop synchroniser plus edge history
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= crystalIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Edge divider, cleared while the source is unused
  always_ff @(posedge clk)
  begin
    if (reset || !tickPort.run)
      div_q <= '0;
    else if (rise)
      div_q <= div_q + 6'h01;
  end

  // One pulse per 64 crystal edges
  always_ff @(posedge clk)
  begin
    if (reset)
      tick_q <= 1'b0;
    else
      tick_q <= tickPort.run & rise & (div_q == btr_pkg::RTC_DIV_LAST);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_tick_single;
    tick_q |=> !tick_q;
  endproperty
  a_tick_single: assert property (p_tick_single)
    else $error("crystal tick longer than one cycle");
endmodule

/* File: bench/tb_btr_timer.sv */
// Self-checking testbench for the basic 8-bit timer with RTC source
module tb_btr_timer;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk; // 200 MHz instruction clock
  logic reset; // Synchronous reset, active high
  logic [7:0] regAddr; // Register address
  logic [7:0] regWdata; // Register write data
  logic regWr; // Write strobe
  logic regRd; // Read strobe
  logic [7:0] regRdata; // Read data
  logic crystalIn; // Crystal level, driven here
  logic [1:0] powerMode; // System power mode
  logic irqReq; // Overflow request
  logic [7:0] irqVector; // Request vector
  logic wakeUp; // Green wake pulse
  logic [1:0] resumeMode; // Mode to return to
  logic eventIrq; // Masked status interrupt
  int numErrors = 0; // Mismatches seen
  int numChecks = 0; // Comparisons made

  btr_timer dut (
    .clk(clk),
    .reset(reset),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .crystalIn(crystalIn),
    .powerMode(powerMode),
    .irqReq(irqReq),
    .irqVector(irqVector),
    .wakeUp(wakeUp),
    .resumeMode(resumeMode),
    .eventIrq(eventIrq)
  );

  // Clock generator
  always #2.5 clk = ~clk;

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic closeOut();
    if (numErrors == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  // Crystal rising edges, ten core cycles per crystal period
  task automatic crystalEdges(input int n);
    repeat (n)
    begin
      repeat (5) @(posedge clk);
      crystalIn <= 1'b1;
      repeat (5) @(posedge clk);
      crystalIn <= 1'b0;
    end
  endtask

  // Reset values, field layout, unmapped address, hold while stopped
  task automatic testRegisters();
    logic [7:0] v;
    for (int i = 0; i < 5; i++)
    begin
      rd(btr_pkg::MODE_OFS + 8'(i), v);
      check("reset value", v, 8'h00);
    end
    wr(8'hdd, 8'hff);
    rd(8'hdd, v);
    check("unmapped", v, 8'h00);
    wr(btr_pkg::MODE_OFS, 8'h7f);
    rd(btr_pkg::MODE_OFS, v);
    check("mode bits", v, 8'h71);
    wr(btr_pkg::MODE_OFS, 8'h00);
    wr(btr_pkg::COUNT_OFS, 8'ha5);
    repeat (600) @(posedge clk);
    rd(btr_pkg::COUNT_OFS, v);
    check("count held", v, 8'ha5);
    check("vector", irqVector, btr_pkg::IRQ_VECTOR);
  endtask

  // Every prescale setting: four steps in four divider periods
  task automatic testRates();
    logic [7:0] a;
    logic [7:0] b;
    int p;
    for (int r = 0; r < 8; r++)
    begin
      p = 256 >> r;
      wr(btr_pkg::COUNT_OFS, 8'h00);
      // Rate first, enable in a later write
      wr(btr_pkg::MODE_OFS, 8'(r << 4));
      wr(btr_pkg::MODE_OFS, 8'h80 | 8'(r << 4));
      rd(btr_pkg::COUNT_OFS, a);
      repeat (4 * p - 2) @(posedge clk);
      rd(btr_pkg::COUNT_OFS, b);
      check("steps per rate", b - a, 8'h04);
      wr(btr_pkg::MODE_OFS, 8'h00);
    end
  endtask

  // Wrap in green mode: flag, request, wake, status and mask
  task automatic testOverflow();
    logic [7:0] v;
    int i;
    // Change the power mode only on a clock edge
    @(posedge clk);
    powerMode <= 2'(btr_pkg::PWR_SLOW);
    wr(btr_pkg::MASK_OFS, 8'h00);
    wr(btr_pkg::IRQCTL_OFS, 8'h02);
    wr(btr_pkg::COUNT_OFS, 8'hff);
    powerMode <= 2'(btr_pkg::PWR_GREEN);
    wr(btr_pkg::MODE_OFS, 8'h80);
    for (i = 0; i < 600; i++)
    begin
      @(posedge clk);
      #1;
      if (wakeUp === 1'b1)
        break;
    end
    check("wake seen", 8'(i < 600), 8'h01);
    check("resume mode", 8'(resumeMode), 8'(btr_pkg::PWR_SLOW));
    check("request", 8'(irqReq), 8'h01);
    check("masked event", 8'(eventIrq), 8'h00);
    wr(btr_pkg::MODE_OFS, 8'h00);
    powerMode <= 2'(btr_pkg::PWR_NORMAL);
    rd(btr_pkg::COUNT_OFS, v);
    check("count after wrap", v, 8'h00);
    rd(btr_pkg::IRQCTL_OFS, v);
    check("flag set", v, 8'h03);
    wr(btr_pkg::MASK_OFS, 8'h01);
    #1 check("unmasked event", 8'(eventIrq), 8'h01);
    rd(btr_pkg::STATUS_OFS, v);
    check("status", v, 8'h03);
    rd(btr_pkg::STATUS_OFS, v);
    check("status cleared", v, 8'h00);
    check("event gone", 8'(eventIrq), 8'h00);
    wr(btr_pkg::IRQCTL_OFS, 8'h02);
    rd(btr_pkg::IRQCTL_OFS, v);
    check("flag cleared", v, 8'h02);
    check("request gone", 8'(irqReq), 8'h00);
  endtask

  // Crystal source: one step per 64 edges, rate field ignored
  task automatic testRtc();
    logic [7:0] v;
    wr(btr_pkg::COUNT_OFS, 8'h00);
    // Source and rate first, enable in a later write
    wr(btr_pkg::MODE_OFS, 8'h71);
    wr(btr_pkg::MODE_OFS, 8'hf1);
    crystalEdges(128);
    repeat (10) @(posedge clk);
    rd(btr_pkg::COUNT_OFS, v);
    check("rtc two steps", v, 8'h02);
    crystalEdges(63);
    repeat (10) @(posedge clk);
    rd(btr_pkg::COUNT_OFS, v);
    check("rtc no extra step", v, 8'h02);
    crystalEdges(1);
    repeat (10) @(posedge clk);
    rd(btr_pkg::COUNT_OFS, v);
    check("rtc third step", v, 8'h03);
    wr(btr_pkg::MODE_OFS, 8'h00);
  endtask

  // Main sequence
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    crystalIn = 1'b0;
    powerMode = 2'(btr_pkg::PWR_NORMAL);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    testRegisters();
    testRates();
    testOverflow();
    testRtc();
    closeOut();
  end

  // Watchdog, about four times the expected run
  initial
  begin
    #100us;
    numErrors++;
    closeOut();
  end
endmodule
